// *** pkg/ffio_defs.svh ***
// constants and contract list for the four flexible i/o ports
//
// Contract
// - four independent ports, each digital input, digital output or analog input
// - a port's mode follows which control-side signal is defined
// - output mode grounds the pin from command rise while command stays high
// - output low with pull-up enabled releases switch, pin pulled to +5V
// - pull-up off and command low leaves the pin floating
// - per-port pull-up, enabled while its disable input is low
// - input mode flag high while pin is below +2.5V, low otherwise
// - input mode with pull-up off reads constantly low
// - analog value is unsigned 16 bits over 0 to +10V
// - analog value published only after change of at least min delta
`ifndef FFIO_DEFS_SVH
`define FFIO_DEFS_SVH
`define FFIO_NPORTS      4
`define FFIO_AWIDTH      16
`define FFIO_MIN_DEFAULT 16'h0800
`define FFIO_ZERO16      16'h0000
`define FFIO_SWITCH_RST  1'h0
`define FFIO_PULLUP_RST  1'h1
`define FFIO_FLAG_RST    1'h0
`define FFIO_PULSE_RST   1'h0
`endif

// *** pkg/ffio_pkg.sv ***
// types shared by the four flexible i/o ports
`include "ffio_defs.svh"
package ffio_pkg;
    typedef enum logic [1:0] {
        FFIO_MODE_IDLE,
        FFIO_MODE_DOUT,
        FFIO_MODE_DIN,
        FFIO_MODE_AIN
    } ffio_mode_t;

    typedef struct packed {
        logic       out_defined;   // digital output command is defined
        logic       din_defined;   // digital input flag is defined
        logic       ain_defined;   // analog input value is defined
    } ffio_sel_t;
endpackage

// *** core/ffio_ports.sv ***
// four flexible i/o ports: digital out, digital in, analog in
`timescale 1ns/100ps
`default_nettype none
`include "ffio_defs.svh"
module ffio_ports #(
    parameter int NPORTS = `FFIO_NPORTS,
    parameter int AW     = `FFIO_AWIDTH
) (
    input  wire logic                       mclk,             // 25 mhz clock
    input  wire logic                       reset_n,          // async reset, active low
    input  wire ffio_pkg::ffio_sel_t [NPORTS-1:0] port_sel,   // which signal is defined
    input  wire logic [NPORTS-1:0]          port_out_cmd,     // output command, high grounds
    input  wire logic [NPORTS-1:0]          pullup_off,       // pull-up disable per port
    input  wire logic [NPORTS-1:0]          min_delta_wr,     // load new min delta
    input  wire logic [AW-1:0]              min_delta_in,     // min delta write data
    input  wire logic [NPORTS-1:0]          pin_below_half,   // async comparator, pin < 2.5v
    input  wire logic [NPORTS*AW-1:0]       adc_sample,       // converter result per port
    input  wire logic [NPORTS-1:0]          adc_valid,        // converter sample strobe
    output logic [NPORTS-1:0]               ground_switch,    // closes pin to ground
    output logic [NPORTS-1:0]               pullup_en,        // pull-up resistor connected
    output logic [NPORTS-1:0]               port_in_flag,     // digital input flag
    output logic [NPORTS*AW-1:0]            port_in_value,    // published analog values
    output logic [NPORTS-1:0]               port_in_update,   // pulse on new analog value
    output ffio_pkg::ffio_mode_t [NPORTS-1:0] port_mode       // decoded mode per port
);

    // ----------------------------------------------------------------
    // mode decode
    // ----------------------------------------------------------------
    // conflicting definitions are the program's fault; output wins
    function automatic ffio_pkg::ffio_mode_t decode_mode(input ffio_pkg::ffio_sel_t s);
        if (s.out_defined)
            return ffio_pkg::FFIO_MODE_DOUT;
        else if (s.ain_defined)
            return ffio_pkg::FFIO_MODE_AIN;
        else if (s.din_defined)
            return ffio_pkg::FFIO_MODE_DIN;
        else
            return ffio_pkg::FFIO_MODE_IDLE;
    endfunction

    // unsigned distance, taken the right way round so it never wraps
    function automatic logic [AW-1:0] abs_diff(
        input logic [AW-1:0] a,
        input logic [AW-1:0] b
    );
        return (a > b) ? a - b : b - a;
    endfunction

    // a distance equal to the threshold already counts as a change
    function automatic logic moved_enough(
        input logic [AW-1:0] s,
        input logic [AW-1:0] c,
        input logic [AW-1:0] t
    );
        return abs_diff(s, c) >= t;
    endfunction

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [AW-1:0] MIN_RST   = AW'(`FFIO_MIN_DEFAULT);
    localparam logic [AW-1:0] VALUE_RST = AW'(`FFIO_ZERO16);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    // several definitions at once fall back to the decode priority
    logic [NPORTS-1:0]                 sync1_reg;      // first stage, may go metastable
    logic [NPORTS-1:0]                 sync2_reg;      // second stage, safe to read
    logic [NPORTS*AW-1:0]              min_delta_reg;  // per-port publish threshold
    ffio_pkg::ffio_mode_t [NPORTS-1:0] mode_reg;       // registered decoded mode
    logic [NPORTS-1:0]                 gnd_reg;        // grounding switch state
    logic [NPORTS-1:0]                 pullup_reg;     // pull-up connection state
    logic [NPORTS-1:0]                 flag_reg;       // digital input flag
    logic [NPORTS*AW-1:0]              value_reg;      // last published analog value
    logic [NPORTS-1:0]                 update_reg;     // one-cycle publish pulse

    // ----------------------------------------------------------------
    // per-port logic
    // ----------------------------------------------------------------
    // converter sample and strobe already run on mclk, so no synchroniser
    genvar g;
    for (g = 0; g < NPORTS; g++) begin : g_port
        ffio_pkg::ffio_mode_t mode_next;
        logic                 dout_mode;
        logic                 din_mode;
        logic                 ain_mode;

        logic                 gnd_next;
        logic                 pullup_next;
        logic                 flag_next;
        logic                 publish;
        logic [AW-1:0]        sample;
        logic [AW-1:0]        cur;
        logic [AW-1:0]        thr;
        logic [AW-1:0]        delta_next;
        logic [AW-1:0]        value_next;
        logic                 update_next;

        assign sample = adc_sample[g*AW +: AW];
        assign cur    = value_reg[g*AW +: AW];
        assign thr    = min_delta_reg[g*AW +: AW];

        // ------------------------------------------------------------
        // next-state terms
        // ------------------------------------------------------------
        assign mode_next   = decode_mode(port_sel[g]);
        assign dout_mode   = (mode_next == ffio_pkg::FFIO_MODE_DOUT);
        assign din_mode    = (mode_next == ffio_pkg::FFIO_MODE_DIN);
        assign ain_mode    = (mode_next == ffio_pkg::FFIO_MODE_AIN);

        // switch follows command level, so it closes at its rising edge
        assign gnd_next    = dout_mode
                             && port_out_cmd[g];
        // an undefined disable input must already read low when it gets here
        assign pullup_next = !pullup_off[g];
        // without the pull-up the pin floats, so reading is forced low
        assign flag_next   = din_mode && pullup_reg[g]
                             && sync2_reg[g];

        assign delta_next  = min_delta_wr[g] ? min_delta_in : thr;
        // hysteresis keeps jitter on the sensor from flooding the program
        assign publish     = ain_mode && adc_valid[g]
                             && moved_enough(sample, cur, thr);
        assign value_next  = publish ? sample : cur;
        assign update_next = publish;

        // ------------------------------------------------------------
        // registers
        // ------------------------------------------------------------
        // an idle port keeps its switch open, its flag low and its value
        // registered so the program sees the mode the pins act on
        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
                mode_reg[g] <= ffio_pkg::FFIO_MODE_IDLE;
            end else begin
                mode_reg[g] <= mode_next;
            end
        end

        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
                gnd_reg[g] <= `FFIO_SWITCH_RST;
            end else begin
                gnd_reg[g] <= gnd_next;
            end
        end

        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
                pullup_reg[g] <= `FFIO_PULLUP_RST;
            end else begin
                pullup_reg[g] <= pullup_next;
            end
        end

        // flag lags the pin by three cycles: two stages and this register
        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
                flag_reg[g] <= `FFIO_FLAG_RST;
            end else begin
                flag_reg[g] <= flag_next;
            end
        end

        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
                min_delta_reg[g*AW +: AW] <= MIN_RST;
            end else begin
                min_delta_reg[g*AW +: AW] <= delta_next;
            end
        end

        // a port leaving analog mode keeps its last published value
        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
                value_reg[g*AW +: AW] <= VALUE_RST;
            end else begin
                value_reg[g*AW +: AW] <= value_next;
            end
        end

        // pulse lasts one cycle; the program must catch it then
        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
                update_reg[g] <= `FFIO_PULSE_RST;
            end else begin
                update_reg[g] <= update_next;
            end
        end
    end

    // ----------------------------------------------------------------
    // comparator synchroniser
    // ----------------------------------------------------------------
    // only stage two is read; stage one may still be settling
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_reg <= '0;
        end else begin
            sync1_reg <= pin_below_half;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sync2_reg <= '0;
        end else begin
            sync2_reg <= sync1_reg;
        end
    end

    // ----------------------------------------------------------------
    // outputs, all straight from flip-flops
    // ----------------------------------------------------------------
    assign ground_switch  = gnd_reg;
    assign pullup_en      = pullup_reg;
    assign port_in_flag   = flag_reg;
    assign port_in_value  = value_reg;
    assign port_in_update = update_reg;
    assign port_mode      = mode_reg;

endmodule // ffio_ports
`default_nettype wire

// *** verification/ffio_pin_model.sv ***
// pin-side model: contact closures and a floating pin
`timescale 1ns/100ps
`default_nettype none
module ffio_pin_model (
    input  wire logic       mclk,           // clock
    input  wire logic [3:0] ground_switch,  // device switch
    input  wire logic [3:0] pullup_en,      // device pull-up
    input  wire logic [3:0] ext_short,      // external short to ground
    output logic      [3:0] pin_below_half  // comparator result
);
    logic tog = 1'b0;
    // a floating pin never holds a value
    always @(posedge mclk) tog <= ~tog;
    assign pin_below_half = ground_switch | ext_short | (~pullup_en & {4{tog}});
endmodule // ffio_pin_model
`default_nettype wire

// *** verification/ffio_ports_checker.sv ***
// assertions on the flexible i/o port pins
`timescale 1ns/100ps
`default_nettype none
module ffio_ports_checker #(
    parameter int NPORTS = 4,  // ports watched
    parameter int AW     = 16  // analog width
) (
    input wire logic                              mclk,           // clock
    input wire logic                              reset_n,        // reset, active low
    input wire ffio_pkg::ffio_sel_t [NPORTS-1:0]  port_sel,       // mode select
    input wire logic [NPORTS-1:0]                 port_out_cmd,   // output command
    input wire logic [NPORTS-1:0]                 pullup_off,     // pull-up disable
    input wire logic [NPORTS-1:0]                 min_delta_wr,   // threshold load
    input wire logic [NPORTS-1:0]                 adc_valid,      // sample strobe
    input wire logic [NPORTS-1:0]                 pin_below_half, // comparator
    input wire logic [NPORTS-1:0]                 ground_switch,  // switch state
    input wire logic [NPORTS-1:0]                 pullup_en,      // pull-up state
    input wire logic [NPORTS-1:0]                 port_in_flag,   // digital flag
    input wire logic [NPORTS-1:0]                 port_in_update, // publish pulse
    input wire logic [AW-1:0]                     min_delta_in,   // threshold data
    input wire logic [NPORTS*AW-1:0]              adc_sample,     // raw samples
    input wire logic [NPORTS*AW-1:0]              port_in_value,  // published values
    input wire ffio_pkg::ffio_mode_t [NPORTS-1:0] port_mode       // decoded mode
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    wire logic din0 = port_mode[0] == ffio_pkg::FFIO_MODE_DIN && pullup_en[0];
    AST_RESET: assert property ($rose(reset_n) |-> pullup_en == '1 && !ground_switch)
        else $error("bad reset");
    AST_GND_ON: assert property (port_sel[0][2] && port_out_cmd[0] |=> ground_switch[0])
        else $error("switch open");
    AST_GND_OFF: assert property (!port_out_cmd[0] |=> !ground_switch[0])
        else $error("switch closed");
    AST_IN_HIGH: assert property ((din0 && pin_below_half[0])[*4] |=> port_in_flag[0])
        else $error("flag low");
    AST_IN_SYNC: assert property (din0 && $rose(pin_below_half[0]) |-> ##2 !port_in_flag[0])
        else $error("flag early");
    AST_NO_PU: assert property (!pullup_en[0] |=> !port_in_flag[0])
        else $error("flag high");
    AST_PUBLISH: assert property (port_in_update[0] |-> $past(adc_valid[0]))
        else $error("stray update");
    AST_MODE_AIN: assert property (port_sel[0] == 3'b001 |=> port_mode[0] == 2'h3)
        else $error("bad mode");
    cover property (port_in_update[0]);
    cover property (port_in_flag[0]);
    cover property (ground_switch[0]);
endmodule // ffio_ports_checker
bind ffio_ports ffio_ports_checker #(.NPORTS(NPORTS), .AW(AW)) u_ffio_ports_checker (.mclk,
    .reset_n, .port_sel, .port_out_cmd, .pullup_off, .min_delta_wr, .adc_valid, .pin_below_half,
    .ground_switch, .pullup_en, .port_in_flag, .port_in_update, .min_delta_in, .adc_sample,
    .port_in_value, .port_mode);
`default_nettype wire

// *** verification/tb_ffio_ports.sv ***
// self-checking bench for the flexible i/o ports
`timescale 1ns/100ps
`default_nettype none
`define chk(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin miscompares++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb_ffio_ports;
    logic mclk = 1'b0, reset_n = 1'b0;
    ffio_pkg::ffio_sel_t [3:0] port_sel = '0;
    logic [3:0] port_out_cmd = '0, pullup_off = '0, min_delta_wr = '0, adc_valid = '0, ext_short = '0;
    logic [15:0] min_delta_in = '0;
    logic [63:0] adc_sample = '0;
    wire logic [3:0] pin_below_half, ground_switch, pullup_en, port_in_flag, port_in_update;
    wire logic [63:0] port_in_value;
    wire ffio_pkg::ffio_mode_t [3:0] port_mode;
    int miscompares = 0, checks_done = 0;
    ffio_ports u_ffio_ports (.mclk, .reset_n, .port_sel, .port_out_cmd, .pullup_off, .min_delta_wr,
        .min_delta_in, .pin_below_half, .adc_sample, .adc_valid, .ground_switch, .pullup_en,
        .port_in_flag, .port_in_value, .port_in_update, .port_mode);
    ffio_pin_model u_ffio_pin_model (.mclk, .ground_switch, .pullup_en, .ext_short, .pin_below_half);
    initial forever #20 mclk = ~mclk;
    task automatic tick(int n); repeat (n) @(posedge mclk); #1; endtask
    task automatic adc_push(logic [15:0] s, logic upd, logic [15:0] v);
        @(posedge mclk) adc_sample <= {4{s}}; adc_valid <= 4'hF;
        @(posedge mclk) adc_valid <= 4'h0; #1;
        `chk("update", {4{upd}}, port_in_update)
        `chk("value", {4{v}}, port_in_value)
    endtask
    task automatic complete_run;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1; #1;
        `chk("pullup", 4'hF, pullup_en)
        `chk("switch", 4'h0, ground_switch)
        `chk("mode", {4{ffio_pkg::FFIO_MODE_IDLE}}, port_mode)
        @(posedge mclk) port_sel <= {4{3'h4}}; port_out_cmd <= 4'h5;
        tick(2); `chk("ground", 4'h5, ground_switch)
        `chk("mode", {4{ffio_pkg::FFIO_MODE_DOUT}}, port_mode)
        @(posedge mclk) port_out_cmd <= 4'hA; pullup_off <= 4'h3;
        tick(2); `chk("release", 4'hA, ground_switch)
        `chk("pullup", 4'hC, pullup_en)
        @(posedge mclk) port_sel <= {4{3'h2}}; port_out_cmd <= 4'h0; pullup_off <= 4'h0;
        tick(5); `chk("idle", 4'h0, port_in_flag)
        `chk("mode", {4{ffio_pkg::FFIO_MODE_DIN}}, port_mode)
        @(posedge mclk) ext_short <= 4'h9;
        tick(5); `chk("flag", 4'h9, port_in_flag)
        @(posedge mclk) pullup_off <= 4'hF;
        tick(4); `chk("no pullup", 4'h0, port_in_flag)
        @(posedge mclk) pullup_off <= 4'h0; ext_short <= 4'h0; port_sel <= {4{3'h1}};
        tick(2);
        `chk("mode", {4{ffio_pkg::FFIO_MODE_AIN}}, port_mode)
        adc_push(16'h07FF, 1'b0, 16'h0000);
        adc_push(16'h0800, 1'b1, 16'h0800);
        @(posedge mclk) min_delta_wr <= 4'hF; min_delta_in <= 16'h000A;
        @(posedge mclk) min_delta_wr <= 4'h0;
        adc_push(16'h0809, 1'b0, 16'h0800);
        adc_push(16'h07F6, 1'b1, 16'h07F6);
        adc_push(16'hFFFF, 1'b1, 16'hFFFF);
        complete_run();
    end
    initial begin
        repeat (1000) @(posedge mclk);
        miscompares++;
        complete_run();
    end
endmodule // tb_ffio_ports
`default_nettype wire
